// file: src/rf_fe_mode_ctrl.sv
// front-end mode controller: drives the two firmware lines of the external
// amplifier, runs the stack-start sequence and sleep/wake mode changes
// assumes APB master on core_clk_in; radio status pins are asynchronous
//
// Overview of operation
// - enable low: select low gives mode 0, select high gives mode 1
// - enable high, select low gives mode 2, amplifiers bypassed
// - enable high, select high gives mode 3, high power and gain
// - transmit without extended range uses bypass so signal reaches antenna
// - off modes radiate nothing; no transmission is expected there
// - amplifier enable on P3[2] follows the link layer, not firmware
// - receive amplifier enable on P3[3] follows the link layer
// - mode and enable lines are plain firmware outputs on P0[2], P0[3]
// - stack start: enable, then select, then write 0x0331, 0x80000302
// - pin-routing register at 0x40030008, accessed as a 32-bit word
// - radio transmit power -6 dBm while external amplifier active
// - before sleep the front end goes to mode 0 or mode 1
// - wake-up with extended range sets mode 3 first
// - change to bypass only once the radio event is finished
// - bypass is never used as a low-power state
//
// The APB slave port is this design's own decision.
module rf_fe_mode_ctrl
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // system events, one-cycle pulses
  input wire logic stack_started_event_in,
  input wire logic sleep_req_in,
  input wire logic wake_req_in,
  // link layer, asynchronous
  input wire logic ll_pa_en_in,
  input wire logic ll_lna_en_in,
  input wire logic rf_busy_in,
  // front-end pins
  output logic front_end_enable_line_out,
  output logic front_end_mode_select_out,
  output logic pa_enable_out,
  output logic lna_enable_out,
  output logic [7:0] tx_power_out,
  output logic sleep_ready_out
);
`include "rf_fe_map.svh"

  // ====================================================================
  // state
  rf_fe_pkg::seq_state_t state;
  rf_fe_pkg::seq_state_t next_state;
  logic enable_line;
  logic select_line;
  logic [`FE_CTRL_WIDTH-1:0] ctrl;
  logic [31:0] pin_route;
  logic [31:0] rf_config;
  logic [7:0] tx_power;
  logic bypass_pending;
  logic asleep;
  logic [1:0] pa_sync;
  logic [1:0] lna_sync;
  logic [1:0] busy_sync;
  logic [1:0] mode;

  // ====================================================================
  // synchronisers: stage 0 feeds stage 1 only
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      pa_sync <= 2'h0;
      lna_sync <= 2'h0;
      busy_sync <= 2'h0;
    end
    else
    begin
      pa_sync <= {pa_sync[0], ll_pa_en_in};
      lna_sync <= {lna_sync[0], ll_lna_en_in};
      busy_sync <= {busy_sync[0], rf_busy_in};
    end
  end

  wire logic pa_req = pa_sync[1];
  wire logic lna_req = lna_sync[1];
  wire logic rf_busy = busy_sync[1];

  // ====================================================================
  // apb decode
  wire logic apb_acc = psel_in & penable_in;
  wire logic [11:0] reg_addr = paddr_in[11:0];
  wire logic hit_ctrl = reg_addr == `FE_ADDR_CTRL;
  wire logic hit_status = reg_addr == `FE_ADDR_STATUS;
  wire logic hit_route = reg_addr == `FE_ADDR_PIN_ROUTE;
  wire logic hit_cfg = reg_addr == `FE_ADDR_RF_CONFIG;
  wire logic hit_pwr = reg_addr == `FE_ADDR_TX_POWER;
  wire logic hit_any = hit_ctrl | hit_status | hit_route | hit_cfg | hit_pwr;
  wire logic wr_ctrl = apb_acc & pwrite_in & hit_ctrl;
  wire logic wr_route = apb_acc & pwrite_in & hit_route;
  wire logic wr_cfg = apb_acc & pwrite_in & hit_cfg;
  wire logic wr_pwr = apb_acc & pwrite_in & hit_pwr;
  function automatic rf_fe_pkg::seq_state_t rf_rf_run();
    return rf_fe_pkg::SEQ_RUN;
  endfunction

  wire logic running = state == rf_rf_run();

  // requested mode from software control bits
  wire logic [1:0] req_mode = {ctrl[`FE_CTRL_ENABLE_BIT],
    ctrl[`FE_CTRL_SELECT_BIT]};
  wire logic req_bypass = req_mode == rf_fe_pkg::MODE_BYPASS;
  // bypass waits for the radio to go quiet
  wire logic hold_bypass = req_bypass & rf_busy;

  assign pready_out = 1'b1;
  assign pslverr_out = apb_acc & ~hit_any;

  // ====================================================================
  // stack-start sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      rf_fe_pkg::SEQ_IDLE:
        if (stack_started_event_in)
          next_state = rf_fe_pkg::SEQ_ENABLE;
      rf_fe_pkg::SEQ_ENABLE: next_state = rf_fe_pkg::SEQ_SELECT;
      rf_fe_pkg::SEQ_SELECT: next_state = rf_fe_pkg::SEQ_CONFIG;
      rf_fe_pkg::SEQ_CONFIG: next_state = rf_fe_pkg::SEQ_ROUTE;
      rf_fe_pkg::SEQ_ROUTE: next_state = rf_fe_pkg::SEQ_RUN;
      rf_fe_pkg::SEQ_RUN: next_state = rf_fe_pkg::SEQ_RUN;
      default: next_state = rf_fe_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      state <= rf_fe_pkg::SEQ_IDLE;
    else
      state <= next_state;
  end

  // ====================================================================
  // control lines
  // sleep forces mode 0/1 (select bit kept); wake with extended range
  // forces mode 3 before anything else
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      enable_line <= 1'b0;
      select_line <= 1'b0;
      asleep <= 1'b0;
    end
    else if (state == rf_fe_pkg::SEQ_ENABLE)
      enable_line <= 1'b1;
    else if (state == rf_fe_pkg::SEQ_SELECT)
      select_line <= 1'b1;
    else if (running & sleep_req_in)
    begin
      enable_line <= 1'b0;
      asleep <= 1'b1;
    end
    else if (running & wake_req_in)
    begin
      asleep <= 1'b0;
      if (ctrl[`FE_CTRL_XRANGE_BIT])
      begin
        enable_line <= 1'b1;
        select_line <= 1'b1;
      end
    end
    else if (running & ~asleep & ~hold_bypass)
    begin
      enable_line <= req_mode[1];
      select_line <= req_mode[0];
    end
  end

  assign bypass_pending = running & hold_bypass;
  assign mode = {enable_line, select_line};

  // ====================================================================
  // registers
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ctrl <= `FE_CTRL_RESET;
      pin_route <= `FE_REG_RESET;
      rf_config <= `FE_REG_RESET;
      tx_power <= `FE_TX_POWER_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= pwdata_in[`FE_CTRL_WIDTH-1:0];
      else if (state == rf_fe_pkg::SEQ_SELECT)
        ctrl <= {1'b1, 2'h3};
      if (state == rf_fe_pkg::SEQ_CONFIG)
        rf_config <= `FE_RF_CONFIG_START;
      else if (wr_cfg)
        rf_config <= pwdata_in;
      if (state == rf_fe_pkg::SEQ_ROUTE)
        pin_route <= `FE_PIN_ROUTE_START;
      else if (wr_route)
        pin_route <= pwdata_in;
      if (state == rf_fe_pkg::SEQ_ROUTE)
        tx_power <= `FE_TX_POWER_EXT;
      else if (wr_pwr)
        tx_power <= pwdata_in[7:0];
    end
  end

  // ====================================================================
  // read data
  wire logic [31:0] status_word = {24'h0, 1'b0, state, asleep,
    bypass_pending, mode};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {29'h0, ctrl} :
    hit_status ? status_word :
    hit_route ? pin_route :
    hit_cfg ? rf_config :
    hit_pwr ? {24'h0, tx_power} : 32'h0;

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      prdata_out <= 32'h0;
    else if (psel_in & ~penable_in & ~pwrite_in)
      prdata_out <= rd_mux;
  end

  // ====================================================================
  // pin outputs; amplifier enables only while the link layer owns them
  // and the front end is on, registered, so an off mode drives the amplifier for at most one cycle
  wire logic ll_owns = pin_route[`FE_PIN_ROUTE_LL_BIT];
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      pa_enable_out <= 1'b0;
      lna_enable_out <= 1'b0;
    end
    else
    begin
      pa_enable_out <= ll_owns & enable_line & pa_req;
      lna_enable_out <= ll_owns & enable_line & lna_req;
    end
  end

  assign front_end_enable_line_out = enable_line;
  assign front_end_mode_select_out = select_line;
  assign tx_power_out = tx_power;
  assign sleep_ready_out = asleep;

  // ====================================================================
  // checks
  sequence start_seq;
    state == rf_fe_pkg::SEQ_ENABLE ##1 (enable_line && !select_line) ##1
      select_line ##1 rf_config == `FE_RF_CONFIG_START;
  endsequence

  chk_start_order: assert property (@(posedge core_clk_in)
    disable iff (srst_in) state == rf_fe_pkg::SEQ_ENABLE |-> start_seq)
    else $error("start sequence order wrong");
  chk_route_value: assert property (@(posedge core_clk_in)
    disable iff (srst_in) state == rf_fe_pkg::SEQ_ROUTE |=>
    pin_route == `FE_PIN_ROUTE_START)
    else $error("pin route not loaded");
  chk_power_level: assert property (@(posedge core_clk_in)
    disable iff (srst_in) state == rf_fe_pkg::SEQ_ROUTE |=>
    tx_power_out == `FE_TX_POWER_EXT)
    else $error("tx power not -6 dBm");
  chk_idle_low: assert property (@(posedge core_clk_in)
    disable iff (srst_in) state == rf_fe_pkg::SEQ_IDLE |->
    !enable_line && !select_line)
    else $error("lines active before start");
  chk_sleep_mode: assert property (@(posedge core_clk_in)
    disable iff (srst_in) running && sleep_req_in |=>
    !front_end_enable_line_out && sleep_ready_out)
    else $error("sleep left front end on");
  chk_wake_high: assert property (@(posedge core_clk_in)
    disable iff (srst_in) running && !sleep_req_in && wake_req_in &&
    ctrl[`FE_CTRL_XRANGE_BIT] |=> mode == rf_fe_pkg::MODE_HIGH)
    else $error("wake did not enter mode 3");
  chk_bypass_quiet: assert property (@(posedge core_clk_in)
    disable iff (srst_in) running && $rose(mode == rf_fe_pkg::MODE_BYPASS)
    |-> $past(!rf_busy))
    else $error("bypass entered during rf activity");
  chk_off_silent: assert property (@(posedge core_clk_in)
    disable iff (srst_in) !$past(enable_line) |->
    !pa_enable_out && !lna_enable_out)
    else $error("amplifier enabled in off mode");
  chk_sleep_bypass: assert property (@(posedge core_clk_in)
    disable iff (srst_in) asleep |-> mode != rf_fe_pkg::MODE_BYPASS)
    else $error("bypass used while asleep");
  chk_pa_follow: assert property (@(posedge core_clk_in)
    disable iff (srst_in) ll_owns && enable_line && pa_req |=>
    pa_enable_out)
    else $error("pa enable not following link layer");
  chk_mode_apply: assert property (@(posedge core_clk_in)
    disable iff (srst_in) running && !asleep && !sleep_req_in &&
    !wake_req_in && !hold_bypass && state == rf_fe_pkg::SEQ_RUN |=>
    mode == $past(req_mode))
    else $error("mode lines not following control");

endmodule

// file: pkg/rf_fe_map.svh
// register offsets, field values and sequence constants of the front-end
// mode controller; assumes a 32-bit APB slave on the system clock
`ifndef RF_FE_MAP_SVH
`define RF_FE_MAP_SVH

// ======================================================================
// register byte addresses (low 12 bits decoded)
`define FE_ADDR_CTRL 12'h000
`define FE_ADDR_STATUS 12'h004
`define FE_ADDR_PIN_ROUTE 12'h008
`define FE_ADDR_RF_CONFIG 12'h00C
`define FE_ADDR_TX_POWER 12'h010
// full system address of the pin-routing register
`define FE_PIN_ROUTE_SYS_ADDR 32'h40030008

// ======================================================================
// control register fields
`define FE_CTRL_ENABLE_BIT 0
`define FE_CTRL_SELECT_BIT 1
`define FE_CTRL_XRANGE_BIT 2
`define FE_CTRL_WIDTH 3
`define FE_CTRL_RESET 3'h0

// ======================================================================
// values written on stack start
`define FE_RF_CONFIG_START 32'h00000331
`define FE_PIN_ROUTE_START 32'h80000302
`define FE_REG_RESET 32'h00000000
// radio power code for -6 dBm, signed dBm in low byte
`define FE_TX_POWER_EXT 8'hFA
`define FE_TX_POWER_RESET 8'h00
`define FE_PIN_ROUTE_LL_BIT 31

`endif

// file: pkg/rf_fe_pkg.sv
// types of the front-end mode controller
// assumes rf_fe_map.svh supplies all numeric constants
package rf_fe_pkg;

  // ====================================================================
  // front-end modes: {enable, select}
  typedef enum logic [1:0]
  {
    MODE_OFF = 2'h0,
    MODE_STANDBY = 2'h1,
    MODE_BYPASS = 2'h2,
    MODE_HIGH = 2'h3
  } fe_mode_t;

  // sequencer states, gray codes along the start path
  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'h0,
    SEQ_ENABLE = 3'h1,
    SEQ_SELECT = 3'h3,
    SEQ_CONFIG = 3'h2,
    SEQ_ROUTE = 3'h6,
    SEQ_RUN = 3'h7
  } seq_state_t;

endpackage

// file: sim/fe_amp_model.sv
// behavioural model of the external amplifier and low-noise amplifier
// assumes its four control lines are static levels from the controller
module fe_amp_model
(
  // control lines
  input wire logic enable_in,
  input wire logic select_in,
  input wire logic pa_en_in,
  input wire logic lna_en_in,
  // observed state
  output logic [1:0] mode_out,
  output logic radiate_out,
  output logic tx_gain_out,
  output logic rx_gain_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================================================================
  // mode decode
  // enable is the high bit of the mode number
  assign mode_out = {enable_in, select_in};
  // an off front end cuts the antenna; bypass still lets the signal out
  assign radiate_out = enable_in;
  assign tx_gain_out = enable_in & select_in & pa_en_in;
  assign rx_gain_out = enable_in & select_in & lna_en_in;
endmodule

// file: sim/tb_rf_fe_mode_ctrl.sv
// self-checking bench of the front-end mode controller
// assumes a zero-wait apb slave and the register map of rf_fe_map.svh
`include "rf_fe_map.svh"
module tb_rf_fe_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================================================================
  // signals
  logic core_clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stack_ev = 1'h0;
  logic sleep_rq = 1'h0;
  logic wake_rq = 1'h0;
  // link requests start high so reset shows they are gated off
  logic ll_pa = 1'h1;
  logic ll_lna = 1'h1;
  logic rf_busy = 1'h0;
  logic fe_en;
  logic fe_sel;
  logic pa_en;
  logic lna_en;
  logic [7:0] tx_pow;
  logic slp_rdy;
  logic [1:0] amp_mode;
  logic radiate;
  logic tx_gain;
  logic rx_gain;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  always #20 core_clk_in = ~core_clk_in;

  rf_fe_mode_ctrl dut
  (
    .core_clk_in(core_clk_in), .srst_in(srst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .stack_started_event_in(stack_ev), .sleep_req_in(sleep_rq),
    .wake_req_in(wake_rq), .ll_pa_en_in(ll_pa), .ll_lna_en_in(ll_lna),
    .rf_busy_in(rf_busy), .front_end_enable_line_out(fe_en),
    .front_end_mode_select_out(fe_sel), .pa_enable_out(pa_en),
    .lna_enable_out(lna_en), .tx_power_out(tx_pow),
    .sleep_ready_out(slp_rdy)
  );

  fe_amp_model amp
  (
    .enable_in(fe_en), .select_in(fe_sel), .pa_en_in(pa_en),
    .lna_en_in(lna_en), .mode_out(amp_mode), .radiate_out(radiate),
    .tx_gain_out(tx_gain), .rx_gain_out(rx_gain)
  );

  // ====================================================================
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // one apb transfer; returns at the edge where pready was seen
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'h0;
    @(posedge core_clk_in);
    penable <= 1'h1;
    // only the cycle ceiling ends a wait that never sees pready
    do
    begin
      @(posedge core_clk_in);
    end
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // 0 stack start, 1 sleep, 2 wake; returns at the sampling edge
  task automatic pulse(input int which);
    @(posedge core_clk_in);
    stack_ev <= (which == 0);
    sleep_rq <= (which == 1);
    wake_rq <= (which == 2);
    @(posedge core_clk_in);
    stack_ev <= 1'h0;
    sleep_rq <= 1'h0;
    wake_rq <= 1'h0;
  endtask

  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      conclude();
    end
  end

  // ====================================================================
  // scenarios
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    srst_in <= 1'h0;
    tick(1);
    check({fe_en, fe_sel, pa_en, lna_en, slp_rdy}, 5'h00);
    apb(1'h0, `FE_ADDR_PIN_ROUTE, 32'h0);
    check(rd, `FE_REG_RESET);
    tick(3);
    check({fe_en, fe_sel}, 2'h0);
    pulse(0);
    tick(0);
    check(fe_en, 1'h0);
    tick(1);
    check({fe_en, fe_sel}, 2'h2);
    tick(1);
    check({fe_en, fe_sel}, 2'h3);
    tick(2);
    apb(1'h0, `FE_ADDR_RF_CONFIG, 32'h0);
    check(rd, 32'h00000331);
    apb(1'h0, `FE_PIN_ROUTE_SYS_ADDR, 32'h0);
    check(rd, 32'h80000302);
    apb(1'h0, `FE_ADDR_TX_POWER, 32'h0);
    check(rd[7:0], 8'hFA);
    check(tx_pow, 8'hFA);
    tick(4);
    check({pa_en, lna_en, tx_gain, rx_gain}, 4'hF);
    @(posedge core_clk_in);
    ll_pa <= 1'h0;
    tick(5);
    check({pa_en, lna_en}, 2'h1);
    @(posedge core_clk_in);
    ll_pa <= 1'h1;
    // every mode, from high power down to all off
    for (int m = 3; m >= 0; m--)
    begin
      apb(1'h1, `FE_ADDR_CTRL, {29'h0, 1'h1, m[0], m[1]});
      tick(1);
      check({fe_en, fe_sel}, m[1:0]);
      check(amp_mode, m[1:0]);
      check(radiate, m[1]);
      apb(1'h0, `FE_ADDR_STATUS, 32'h0);
      check(rd[1:0], m[1:0]);
    end
    tick(5);
    check({pa_en, tx_gain}, 2'h0);
    // bypass request held back while the radio is busy
    apb(1'h1, `FE_ADDR_CTRL, 32'h7);
    @(posedge core_clk_in);
    rf_busy <= 1'h1;
    tick(4);
    apb(1'h1, `FE_ADDR_CTRL, 32'h5);
    tick(2);
    check({fe_en, fe_sel}, 2'h3);
    apb(1'h0, `FE_ADDR_STATUS, 32'h0);
    check(rd[2], 1'h1);
    @(posedge core_clk_in);
    rf_busy <= 1'h0;
    tick(5);
    check({fe_en, fe_sel, radiate}, 3'h5);
    // sleep from high power, a blocked write, then wake
    apb(1'h1, `FE_ADDR_CTRL, 32'h7);
    tick(1);
    pulse(1);
    tick(1);
    check({fe_en, fe_sel, slp_rdy}, 3'h3);
    apb(1'h1, `FE_ADDR_CTRL, 32'h7);
    tick(2);
    check({fe_en, fe_sel}, 2'h1);
    pulse(2);
    tick(1);
    check({fe_en, fe_sel, slp_rdy}, 3'h6);
    // sleep from bypass must not stay in bypass
    apb(1'h1, `FE_ADDR_CTRL, 32'h5);
    tick(5);
    pulse(1);
    tick(1);
    check({fe_en, fe_sel, slp_rdy}, 3'h1);
    pulse(2);
    tick(0);
    check({fe_en, fe_sel}, 2'h3);
    // one cycle later the control word asks for bypass again
    tick(1);
    check({fe_en, fe_sel}, 2'h2);
    // unmapped address is refused
    apb(1'h1, 32'h00000020, 32'hFFFFFFFF);
    check(er, 1'h1);
    apb(1'h0, 32'h00000020, 32'h0);
    check(er, 1'h1);
    check(rd, 32'h0);
    conclude();
  end
endmodule
